// *** core/l1_cache_write_buffer.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// store queue
// ----------------------------------------
module store_queue #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 3
) (
	// clock and reset
	input logic clock,
	input logic srst,
	// fill side
	input logic in_valid,
	output logic in_ready,
	input logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {logic [PW-1:0] wp; logic [PW-1:0] rp; logic [PW:0] cnt;} fifo_state_t;
	fifo_state_t q, d;
	logic [WIDTH-1:0] mem [DEPTH];

	function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	assign in_ready = q.cnt != (PW+1)'(DEPTH);
	assign out_valid = q.cnt != '0;
	assign out_data = mem[q.rp];

	always_comb
	begin
		d = q;
		if (in_valid && in_ready)
		begin
			d.wp = next_ptr(q.wp);
		end
		if (out_valid && out_ready)
		begin
			d.rp = next_ptr(q.rp);
		end
		d.cnt = (PW+1)'(q.cnt + (in_valid && in_ready) - (out_valid && out_ready));
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			q <= '0;
		else
			q <= d;
		if (in_valid && in_ready)
			mem[q.wp] <= in_data;
	end
endmodule

// ----------------------------------------
// caches and write path
// ----------------------------------------
module l1_cache_write_buffer (
	// clock and reset
	input logic clock,
	input logic srst,
	// control
	input logic [31:0] cache_control_word,
	input logic [7:0] pnp_cacheable_map,
	// integer pipeline
	input l1_cache_pkg::fetch_req_t fetch_req,
	output l1_cache_pkg::fetch_rsp_t fetch_rsp,
	output logic fetch_stall,
	input l1_cache_pkg::data_req_t data_req,
	output l1_cache_pkg::data_rsp_t data_rsp,
	output l1_cache_pkg::trap_t trap,
	// system bus
	output l1_cache_pkg::ahb_out_t ahb_out,
	input l1_cache_pkg::ahb_in_t ahb_in
);
	import l1_cache_pkg::*;

	core_state_t q, d;
	logic [19:0] itag [2][IC_SETS]; // RULE5
	logic [IC_SUB-1:0] ival [2][IC_SETS];
	logic [31:0] idat [2][WAY_WORDS];
	logic ilru [IC_SETS];
	logic [19:0] dtag [2][DC_SETS];
	logic [DC_SUB-1:0] dval [2][DC_SETS];
	logic [31:0] ddat [2][WAY_WORDS];
	logic dlru [DC_SETS];
	logic [6:0] fi;
	logic [7:0] di;
	logic [1:0] imatch, ihit, dmatch, dhit;
	logic [1:0] istate;
	logic ion, don, burst, icc, dcc, fmiss, lmiss, push, pop, err;
	logic st_in_ready, st_out_valid;
	store_entry_t st_in, st_out;
	logic ic_we, ic_alloc, ic_way, il_we, il_v;
	logic [31:0] ic_a, ic_w, il_a;
	logic dc_we, dc_alloc, dc_way, dl_we, dl_v;
	logic [31:0] dc_a, dc_w, dl_a;

	function automatic logic cacheable(input logic [31:0] a, input logic [7:0] map);
		logic in_range;
		in_range = (a <= BOOT_HI) || (a >= MAIN_LO && a <= MAIN_HI); // RULE1
		return in_range && map[a[31:29]]; // RULE2
	endfunction

	function automatic logic [31:0] replicate(input logic [31:0] v, input logic [1:0] sz);
		case (sz)
			SIZE_BYTE: return {4{v[7:0]}};
			SIZE_HALF: return {2{v[15:0]}};
			default: return v;
		endcase
	endfunction

	// big-endian lanes: offset 0 is the top byte
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [1:0] lo, input logic [1:0] sz);
		logic [3:0] be;
		logic [31:0] r;
		be = 4'hF;
		r = o;
		if (sz == SIZE_BYTE)
			be = 4'h8 >> lo;
		else if (sz == SIZE_HALF)
			be = lo[1] ? 4'h3 : 4'hC;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[8*i+:8] = n[8*i+:8];
		end
		return r;
	endfunction

	// ----------------------------------------
	// lookup
	// ----------------------------------------
	assign fi = fetch_req.addr[11:5];
	assign di = data_req.addr[11:4];
	assign istate = cache_control_word[ISTATE_LO+:2];
	assign ion = istate == ISTATE_FROZEN || istate == ISTATE_ENABLED; // RULE23
	assign don = cache_control_word[DCS_LO];
	assign burst = cache_control_word[CCW_BURST_BIT]; // RULE22
	assign icc = cacheable(fetch_req.addr, pnp_cacheable_map);
	assign dcc = cacheable(data_req.addr, pnp_cacheable_map);

	always_comb
	begin
		for (int w = 0; w < 2; w++)
		begin
			// tags are not reset: a line counts only while it holds a valid word
			imatch[w] = |ival[w][fi] && itag[w][fi] == fetch_req.addr[31:12];
			ihit[w] = imatch[w] && ival[w][fi][fetch_req.addr[4:2]]; // RULE6
			dmatch[w] = |dval[w][di] && dtag[w][di] == data_req.addr[31:12];
			dhit[w] = dmatch[w] && dval[w][di][data_req.addr[3:2]];
		end
	end

	// ----------------------------------------
	// store queue
	// ----------------------------------------
	assign st_in.addr = data_req.addr;
	assign st_in.size = data_req.size;
	assign st_in.data = replicate(data_req.wdata, data_req.size); // RULE19

	store_queue #(
		.WIDTH($bits(store_entry_t)),
		.DEPTH(STORE_DEPTH) // RULE18
	) u_store_holding_queue (
		.clock(clock),
		.srst(srst),
		.in_valid(push),
		.in_ready(st_in_ready),
		.in_data(st_in),
		.out_valid(st_out_valid),
		.out_ready(pop),
		.out_data(st_out)
	);

	// ----------------------------------------
	// control
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.frsp.valid = 1'b0;
		d.frsp.err = 1'b0;
		d.drsp.valid = 1'b0;
		d.drsp.err = 1'b0;
		d.trap.valid = 1'b0;
		fmiss = 1'b0;
		lmiss = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		err = ahb_in.hresp == HRESP_ERROR;
		ic_we = 1'b0;
		ic_alloc = q.alloc;
		ic_way = q.way;
		ic_a = q.daddr;
		ic_w = ahb_in.hrdata;
		il_we = 1'b0;
		il_v = !q.way;
		il_a = q.daddr;
		dc_we = 1'b0;
		dc_alloc = q.alloc;
		dc_way = q.way;
		dc_a = q.daddr;
		dc_w = ahb_in.hrdata;
		dl_we = 1'b0;
		dl_v = !q.way;
		dl_a = q.daddr;
		case (q.fsm)
			ST_IDLE:
			begin
				if (fetch_req.valid && !q.frsp.valid && !q.frsp.err)
				begin
					if (ion && icc && |ihit)
					begin
						d.frsp.valid = 1'b1;
						d.frsp.addr = fetch_req.addr;
						d.frsp.data = idat[ihit[1]][fetch_req.addr[11:2]];
						il_we = 1'b1; // RULE24
						il_a = fetch_req.addr;
						il_v = !ihit[1];
					end
					else
						fmiss = 1'b1;
				end
				if (data_req.valid && !q.drsp.valid)
				begin
					if (data_req.write)
					begin
						if (st_in_ready)
						begin
							push = 1'b1;
							d.drsp.valid = 1'b1;
							// write hits update the copy, misses allocate nothing
							if (don && dcc && |dhit) // RULE16
							begin
								dc_we = 1'b1;
								dc_alloc = 1'b0;
								dc_way = dhit[1];
								dc_a = data_req.addr;
								dc_w = merge(ddat[dhit[1]][data_req.addr[11:2]], st_in.data,
									data_req.addr[1:0], data_req.size);
								dl_we = 1'b1;
								dl_a = data_req.addr;
								dl_v = !dhit[1];
							end
						end
					end
					else if (don && dcc && data_req.asi != ASI_FORCED_MISS && |dhit) // RULE4
					begin
						d.drsp.valid = 1'b1;
						d.drsp.data = ddat[dhit[1]][data_req.addr[11:2]];
						dl_we = 1'b1; // RULE24
						dl_a = data_req.addr;
						dl_v = !dhit[1];
					end
					else
						lmiss = 1'b1;
				end
				d.ahb.hwrite = 1'b0;
				d.ahb.hsize = HSIZE_WORD;
				d.ahb.hburst = HBURST_SINGLE;
				d.left = '0;
				d.abandon = 1'b0;
				d.stall = 1'b0;
				d.stream = 1'b0;
				// a load miss waits until every buffered store has gone out
				if (st_out_valid && (lmiss || !fmiss)) // RULE20
				begin
					d.fsm = ST_WRITE;
					d.ahb.htrans = HTRANS_NONSEQ;
					d.ahb.haddr = st_out.addr;
					d.ahb.hwrite = 1'b1;
					d.ahb.hsize = {1'b0, st_out.size};
					d.ahb.hwdata = st_out.data;
				end
				else if (lmiss)
				begin
					d.fsm = ST_DREAD; // RULE15
					d.ahb.htrans = HTRANS_NONSEQ;
					d.ahb.haddr = {data_req.addr[31:2], 2'h0};
					d.daddr = {data_req.addr[31:2], 2'h0};
					d.fill = don && dcc;
					d.alloc = !(|dmatch);
					d.way = (|dmatch) ? dmatch[1] : dlru[di]; // RULE24
				end
				else if (fmiss)
				begin
					d.fsm = ST_IFILL; // RULE7
					d.ahb.htrans = HTRANS_NONSEQ;
					d.ahb.haddr = {fetch_req.addr[31:2], 2'h0};
					d.ahb.hburst = burst ? HBURST_INCR : HBURST_SINGLE; // RULE12
					d.left = burst ? 3'(IC_LAST_WORD - fetch_req.addr[4:2]) : 3'h0; // RULE8
					d.daddr = {fetch_req.addr[31:2], 2'h0};
					d.fill = icc && (istate == ISTATE_ENABLED
						|| (istate == ISTATE_FROZEN && |imatch)); // RULE23 RULE11
					d.alloc = !(|imatch);
					d.way = (|imatch) ? imatch[1] : ilru[fi]; // RULE24
					d.stream = 1'b1;
				end
			end
			default:
			begin
				if (q.fsm == ST_IFILL && fetch_req.cti)
				begin
					d.abandon = 1'b1; // RULE10
					d.stream = 1'b0;
				end
				if (ahb_in.hready)
				begin
					if (q.dphase)
					begin
						d.daddr = q.daddr + 32'h4;
						case (q.fsm)
							ST_IFILL:
							begin
								if (!err)
								begin
									if (q.fill)
									begin
										ic_we = 1'b1;
										d.alloc = 1'b0;
										il_we = 1'b1; // RULE24
									end
									if (q.stream && !fetch_req.cti)
									begin
										if (fetch_req.ready)
										begin
											d.frsp.valid = 1'b1; // RULE8
											d.frsp.addr = q.daddr;
											d.frsp.data = ahb_in.hrdata;
											if (q.fail_addr == q.daddr)
												d.fail_valid = 1'b0;
										end
										else
										begin
											d.stream = 1'b0; // RULE9
											d.stall = 1'b1;
										end
									end
								end
								// a failed word stays invalid; only a streamed fetch reacts
								else if (q.stream && !fetch_req.cti) // RULE13
								begin
									if (q.fail_valid && q.fail_addr == q.daddr)
									begin
										d.frsp.err = 1'b1; // RULE14
										d.frsp.addr = q.daddr;
										d.trap.valid = 1'b1;
										d.trap.tt = TT_IACC;
										d.fail_valid = 1'b0;
									end
									else
									begin
										d.fail_valid = 1'b1;
										d.fail_addr = q.daddr;
									end
									d.stream = 1'b0;
									d.abandon = 1'b1;
								end
							end
							ST_DREAD:
							begin
								if (err)
								begin
									d.drsp.err = 1'b1; // RULE17
									d.trap.valid = 1'b1;
									d.trap.tt = TT_DACC;
								end
								else
								begin
									d.drsp.valid = 1'b1;
									d.drsp.data = ahb_in.hrdata;
									dc_we = q.fill;
									dl_we = q.fill; // RULE24
								end
							end
							default:
							begin
								pop = 1'b1;
								if (err)
								begin
									d.trap.valid = 1'b1; // RULE21
									d.trap.tt = TT_WERR;
								end
							end
						endcase
					end
					if (q.ahb.htrans != HTRANS_IDLE)
					begin
						d.dphase = 1'b1;
						if (q.left != 3'h0 && !q.abandon && !d.abandon)
						begin
							d.ahb.htrans = HTRANS_SEQ;
							d.ahb.haddr = q.ahb.haddr + 32'h4;
							d.left = q.left - 3'h1;
						end
						else
							d.ahb.htrans = HTRANS_IDLE;
					end
					else
					begin
						d.dphase = 1'b0;
						d.fsm = ST_IDLE;
						d.stall = 1'b0;
					end
				end
				else if (q.dphase && err)
				begin
					// first cycle of an error answer: cancel the pending address
					d.ahb.htrans = HTRANS_IDLE;
					d.left = 3'h0;
				end
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			q <= CORE_RESET;
		else
			q <= d;
	end

	// ----------------------------------------
	// cache arrays: written only by this core's own traffic
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			for (int s = 0; s < IC_SETS; s++)
			begin
				ival[0][s] <= '0;
				ival[1][s] <= '0;
				ilru[s] <= 1'b0;
			end
			for (int s = 0; s < DC_SETS; s++)
			begin
				dval[0][s] <= '0;
				dval[1][s] <= '0;
				dlru[s] <= 1'b0;
			end
		end
		else
		begin
			if (ic_we) // RULE3
			begin
				idat[ic_way][ic_a[11:2]] <= ic_w;
				if (ic_alloc)
				begin
					itag[ic_way][ic_a[11:5]] <= ic_a[31:12];
					ival[ic_way][ic_a[11:5]] <= IC_SUB'(1) << ic_a[4:2]; // RULE6
				end
				else
					ival[ic_way][ic_a[11:5]] <= ival[ic_way][ic_a[11:5]] | (IC_SUB'(1) << ic_a[4:2]);
			end
			if (il_we)
				ilru[il_a[11:5]] <= il_v;
			if (dc_we)
			begin
				ddat[dc_way][dc_a[11:2]] <= dc_w;
				if (dc_alloc)
				begin
					dtag[dc_way][dc_a[11:4]] <= dc_a[31:12];
					dval[dc_way][dc_a[11:4]] <= DC_SUB'(1) << dc_a[3:2];
				end
				else
					dval[dc_way][dc_a[11:4]] <= dval[dc_way][dc_a[11:4]] | (DC_SUB'(1) << dc_a[3:2]);
			end
			if (dl_we)
				dlru[dl_a[11:4]] <= dl_v;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign fetch_rsp = q.frsp;
	assign fetch_stall = q.stall;
	assign data_rsp = q.drsp;
	assign trap = q.trap;
	assign ahb_out = q.ahb;
endmodule

// *** include/l1_cache_pkg.sv ***
// Contract
// RULE1: only boot and main memory ranges are cacheable
// RULE2: cacheability follows the plug-and-play area map
// RULE3: no snooping; other masters' writes leave stale lines
// RULE4: load alternate space 0x01 forces a miss
// RULE5: two ways, 4kB each, 16/32-byte lines, LRU
// RULE6: one tag, one valid bit per word
// RULE7: instruction miss fetches and updates tag and data
// RULE8: burst fill from missed word to line end, streamed
// RULE9: stall pipeline until fill ends if it refuses words
// RULE10: control transfer abandons the fill at next fetch
// RULE11: burst with cache disabled streams without updating
// RULE12: refills are incrementing bursts on the bus
// RULE13: failed fill word keeps its valid bit cleared
// RULE14: repeated fetch failure raises trap 0x01
// RULE15: data read miss loads one 4-byte word
// RULE16: stores write through, no allocate on miss
// RULE17: failed load keeps valid clear, raises trap 0x09
// RULE18: store buffer holds three 32-bit entries
// RULE19: byte and half stores replicated into lanes
// RULE20: store buffer drained before a load-miss fill
// RULE21: failed buffered write traps current instruction 0x2B
// RULE22: burst fetch enable is control bit 16
// RULE23: frozen icache updates lines but never allocates
// RULE24: replace less recently used way, update on use
package l1_cache_pkg;
	localparam logic [31:0] BOOT_HI = 32'h1FFF_FFFF;
	localparam logic [31:0] MAIN_LO = 32'h4000_0000;
	localparam logic [31:0] MAIN_HI = 32'h7FFF_FFFF;
	localparam logic [7:0] ASI_FORCED_MISS = 8'h01;
	localparam logic [7:0] TT_IACC = 8'h01;
	localparam logic [7:0] TT_DACC = 8'h09;
	localparam logic [7:0] TT_WERR = 8'h2B;
	localparam int CCW_BURST_BIT = 16;
	localparam int ISTATE_LO = 0;
	localparam int DCS_LO = 2;
	localparam logic [1:0] ISTATE_FROZEN = 2'h1;
	localparam logic [1:0] ISTATE_ENABLED = 2'h3;
	localparam int IC_SETS = 128;
	localparam int DC_SETS = 256;
	localparam int WAY_WORDS = 1024;
	localparam int IC_SUB = 8;
	localparam int DC_SUB = 4;
	localparam logic [2:0] IC_LAST_WORD = 3'h7;
	localparam int STORE_DEPTH = 3;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HBURST_SINGLE = 3'h0;
	localparam logic [2:0] HBURST_INCR = 3'h1;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HRESP_ERROR = 2'h1;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;

	typedef struct packed {logic valid; logic ready; logic cti; logic [31:0] addr;} fetch_req_t;
	typedef struct packed {logic valid; logic err; logic [31:0] addr; logic [31:0] data;} fetch_rsp_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] asi;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} data_req_t;
	typedef struct packed {logic valid; logic err; logic [31:0] data;} data_rsp_t;
	typedef struct packed {logic valid; logic [7:0] tt;} trap_t;
	typedef struct packed {
		logic [1:0] htrans;
		logic [31:0] haddr;
		logic hwrite;
		logic [2:0] hsize;
		logic [2:0] hburst;
		logic [31:0] hwdata;
	} ahb_out_t;
	typedef struct packed {logic hready; logic [1:0] hresp; logic [31:0] hrdata;} ahb_in_t;
	typedef struct packed {logic [31:0] addr; logic [1:0] size; logic [31:0] data;} store_entry_t;
	typedef enum {ST_IDLE, ST_IFILL, ST_DREAD, ST_WRITE} fsm_t;
	typedef struct packed {
		fsm_t fsm;
		ahb_out_t ahb;
		logic dphase;
		logic [2:0] left;
		logic [31:0] daddr;
		logic way;
		logic fill;
		logic alloc;
		logic stream;
		logic abandon;
		logic stall;
		fetch_rsp_t frsp;
		data_rsp_t drsp;
		trap_t trap;
		logic fail_valid;
		logic [31:0] fail_addr;
	} core_state_t;
	localparam core_state_t CORE_RESET = '0;
endpackage

// *** test/l1_cache_write_buffer_props.sv ***
`timescale 1ns/1ps
module cache_rule_props (
	// clock and reset
	input logic clock,
	input logic srst,
	// integer pipeline
	input l1_cache_pkg::fetch_req_t fetch_req,
	input l1_cache_pkg::fetch_rsp_t fetch_rsp,
	input logic fetch_stall,
	input l1_cache_pkg::data_req_t data_req,
	input l1_cache_pkg::data_rsp_t data_rsp,
	input l1_cache_pkg::trap_t trap,
	// system bus
	input l1_cache_pkg::ahb_out_t ahb_out,
	input l1_cache_pkg::ahb_in_t ahb_in
);
	import l1_cache_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	logic [2:0] held_q;
	logic wdph_q;
	logic load_go;
	assign load_go = data_req.valid && !data_req.write && ahb_out.htrans == HTRANS_NONSEQ
		&& !ahb_out.hwrite && ahb_out.haddr[31:2] == data_req.addr[31:2];
	// stores accepted but not yet put on the bus
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			held_q <= 3'h0;
			wdph_q <= 1'b0;
		end
		else
		begin
			held_q <= held_q + 3'(data_rsp.valid && data_req.write)
				- 3'(ahb_out.htrans == HTRANS_NONSEQ && ahb_out.hwrite && ahb_in.hready);
			if (ahb_in.hready)
				wdph_q <= ahb_out.htrans[1] && ahb_out.hwrite;
		end
	end
	// --------
	// assertions
	// --------
	a_seq_incr_read: assert property (ahb_out.htrans == HTRANS_SEQ
		|-> ahb_out.hburst == HBURST_INCR && !ahb_out.hwrite) else $error("bad seq beat");
	a_seq_next_word: assert property ($past(ahb_in.hready) && ahb_out.htrans == HTRANS_SEQ
		|-> ahb_out.haddr == $past(ahb_out.haddr) + 32'h4) else $error("burst step");
	a_burst_in_line: assert property (ahb_out.htrans == HTRANS_SEQ
		|-> ahb_out.haddr[4:2] != 3'h0) else $error("burst past line end");
	a_fetch_err_trap: assert property (fetch_rsp.err
		|-> trap.valid && trap.tt == TT_IACC) else $error("fetch trap");
	a_load_err_trap: assert property (data_rsp.err
		|-> trap.valid && trap.tt == TT_DACC) else $error("load trap");
	a_write_err_trap: assert property (wdph_q && ahb_in.hready && ahb_in.hresp == HRESP_ERROR
		|-> ##[1:2] trap.valid && trap.tt == TT_WERR) else $error("write trap");
	a_queue_depth: assert property (held_q <= 3'h3) else $error("store queue overrun");
	a_drain_first: assert property (load_go |-> held_q == 3'h0) else $error("load before drain");
	a_load_single: assert property (load_go
		|-> ahb_out.hburst == HBURST_SINGLE && ahb_out.hsize == HSIZE_WORD) else $error("load size");
	a_cti_stops: assert property (fetch_req.cti && ahb_in.hready ##1 ahb_in.hready
		|=> ahb_out.htrans != HTRANS_SEQ) else $error("fill not abandoned");
	a_stall_quiet: assert property (fetch_stall |-> !fetch_rsp.valid) else $error("stream in stall");
	c_burst_seq: cover property (ahb_out.htrans == HTRANS_SEQ);
	c_stall_end: cover property ($fell(fetch_stall));
	c_write_trap: cover property (trap.valid && trap.tt == TT_WERR);
endmodule

bind l1_cache_write_buffer cache_rule_props cache_rule_props_inst (.clock(clock), .srst(srst),
	.fetch_req(fetch_req), .fetch_rsp(fetch_rsp), .fetch_stall(fetch_stall),
	.data_req(data_req), .data_rsp(data_rsp), .trap(trap), .ahb_out(ahb_out), .ahb_in(ahb_in));

// *** test/ahb_mem_model.sv ***
`timescale 1ns/1ps
module ahb_mem_model (
	// clock and reset
	input logic clock,
	input logic srst,
	// system bus
	input l1_cache_pkg::ahb_out_t ahb_out,
	output l1_cache_pkg::ahb_in_t ahb_in,
	// behaviour
	input logic slow,
	input logic err_en,
	input logic [31:0] err_addr
);
	import l1_cache_pkg::*;
	logic [31:0] mem [1024];
	logic [1023:0] wrt_q;
	logic dph_q;
	logic wr_q;
	logic waited_q;
	logic erred_q;
	logic bad;
	logic [31:0] adr_q;
	logic [31:0] last_q;
	assign bad = dph_q && err_en && adr_q == err_addr;
	// idle beats show the inverse of the previous cycle's hrdata, so every second idle cycle repeats the last word
	always_comb
	begin
		ahb_in = '{1'b1, 2'h0, ~last_q};
		if (bad)
		begin
			ahb_in.hready = erred_q;
			ahb_in.hresp = HRESP_ERROR;
		end
		else if (dph_q && slow && !waited_q)
			ahb_in.hready = 1'b0;
		else if (dph_q && !wr_q)
			ahb_in.hrdata = wrt_q[adr_q[11:2]] ? mem[adr_q[11:2]] : {adr_q[15:0], ~adr_q[15:0]};
	end
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			dph_q <= 1'b0;
			waited_q <= 1'b0;
			erred_q <= 1'b0;
			wrt_q <= '0;
		end
		else if (ahb_in.hready)
		begin
			if (dph_q && wr_q && !bad)
			begin
				mem[adr_q[11:2]] <= ahb_out.hwdata;
				wrt_q[adr_q[11:2]] <= 1'b1;
			end
			dph_q <= ahb_out.htrans[1];
			wr_q <= ahb_out.hwrite;
			adr_q <= {ahb_out.haddr[31:2], 2'h0};
			waited_q <= 1'b0;
			erred_q <= 1'b0;
		end
		else
		begin
			waited_q <= 1'b1;
			erred_q <= bad;
		end
		last_q <= srst ? 32'h0 : ahb_in.hrdata;
	end
endmodule

// *** test/l1_cache_write_buffer_tb.sv ***
`timescale 1ns/1ps
module l1_cache_write_buffer_tb;
	import l1_cache_pkg::*;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %s expected %h seen %h", n, e, g); end end
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [31:0] cache_control_word = 32'h0001_0007;
	logic [7:0] pnp_cacheable_map = 8'h0D;
	fetch_req_t fetch_req = '0;
	fetch_rsp_t fetch_rsp;
	logic fetch_stall;
	data_req_t data_req = '0;
	data_rsp_t data_rsp;
	trap_t trap;
	ahb_out_t ahb_out;
	ahb_in_t ahb_in;
	logic slow = 1'b0;
	logic err_en = 1'b0;
	logic [31:0] err_addr = 32'h0;
	int miscompares = 0;
	int comparisons = 0;
	int n_rd = 0;
	logic [31:0] fq[$];
	logic [31:0] tq[$];
	logic [31:0] fd;
	logic [31:0] rd;
	logic fe;
	logic rerr;
	int n_stall = 0;
	always #5 clock = ~clock;
	l1_cache_write_buffer l1_cache_write_buffer_inst (.clock(clock), .srst(srst),
		.cache_control_word(cache_control_word), .pnp_cacheable_map(pnp_cacheable_map),
		.fetch_req(fetch_req), .fetch_rsp(fetch_rsp), .fetch_stall(fetch_stall),
		.data_req(data_req), .data_rsp(data_rsp), .trap(trap), .ahb_out(ahb_out), .ahb_in(ahb_in));
	ahb_mem_model ahb_mem_model_inst (.clock(clock), .srst(srst), .ahb_out(ahb_out),
		.ahb_in(ahb_in), .slow(slow), .err_en(err_en), .err_addr(err_addr));
	// --------
	// monitor
	// --------
	always @(posedge clock)
	begin
		if (fetch_rsp.valid)
			fq.push_back(fetch_rsp.data);
		if (trap.valid)
			tq.push_back({24'h0, trap.tt});
		if (fetch_stall)
			n_stall++;
		if (ahb_in.hready && ahb_out.htrans == HTRANS_NONSEQ && !ahb_out.hwrite)
			n_rd++;
	end
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction
	// --------
	// helpers
	// --------
	task automatic end_sim();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic timeout();
		miscompares++;
		$display("MISMATCH wait expected done seen timeout");
		end_sim();
	endtask
	task automatic cyc();
		@(posedge clock);
		#1;
	endtask
	task automatic fetch(input logic [31:0] a, input logic r);
		int i;
		fetch_req = '{1'b1, r, 1'b0, a};
		cyc();
		for (i = 0; i < 300 && !(fetch_rsp.valid && fetch_rsp.addr == a) && !fetch_rsp.err; i++)
			cyc();
		if (i == 300)
			timeout();
		fd = fetch_rsp.data;
		fe = fetch_rsp.err;
		fetch_req.valid = 1'b0;
		// an edge passes before any following call raises valid again
		cyc();
	endtask
	task automatic access(input logic w, input logic [7:0] asi, input logic [1:0] sz,
		input logic [31:0] a, input logic [31:0] wd);
		int i;
		data_req = '{1'b1, w, asi, sz, a, wd};
		cyc();
		for (i = 0; i < 300 && !data_rsp.valid && !data_rsp.err; i++)
			cyc();
		if (i == 300)
			timeout();
		rd = data_rsp.data;
		rerr = data_rsp.err;
		data_req.valid = 1'b0;
		cyc();
	endtask
	task automatic wait_sz(ref logic [31:0] q[$], input int n);
		int i;
		for (i = 0; i < 300 && q.size() < n; i++)
			cyc();
		if (i == 300)
			timeout();
	endtask
	// --------
	// scenarios
	// --------
	task automatic t_modes();
		logic [31:0] a [5] = '{32'h2000_0000, 32'h6000_0040, 32'h0000_0040, 32'h4000_0200,
			32'h4000_0300};
		logic [7:0] m [5] = '{8'h0D, 8'h05, 8'h0D, 8'h0D, 8'h0D};
		logic [1:0] mode [5] = '{ISTATE_ENABLED, ISTATE_ENABLED, ISTATE_ENABLED, 2'h0,
			ISTATE_FROZEN};
		int c [5] = '{2, 2, 1, 2, 2};
		int r0;
		for (int k = 0; k < 5; k++)
		begin
			pnp_cacheable_map = m[k];
			cache_control_word[1:0] = mode[k];
			r0 = n_rd;
			repeat (2)
			begin
				fetch(a[k], 1'b1);
				`CHK("fetch data", pat(a[k]), fd)
			end
			`CHK("bus reads", c[k], n_rd - r0)
		end
		pnp_cacheable_map = 8'h0D;
		cache_control_word[1:0] = ISTATE_ENABLED;
		$display("test modes done");
	endtask
	task automatic t_burst();
		logic [31:0] lru [6] = '{32'h4000_0400, 32'h4000_1400, 32'h4000_0400, 32'h4000_2400,
			32'h4000_0400, 32'h4000_1400};
		int r0;
		int s0;
		// the previous fill must finish streaming before words are collected
		repeat (12) cyc();
		fq.delete();
		r0 = n_rd;
		fetch(32'h4000_0018, 1'b1);
		wait_sz(fq, 2);
		`CHK("streamed word", pat(32'h4000_001C), fq[1])
		fetch(32'h4000_001C, 1'b1);
		fetch(32'h4000_0014, 1'b1);
		s0 = n_stall;
		fetch(32'h4000_0100, 1'b0);
		fetch(32'h4000_011C, 1'b1);
		`CHK("stall seen", 1'b1, n_stall > s0)
		`CHK("stall end", 1'b0, fetch_stall)
		`CHK("fill reads", 3, n_rd - r0)
		r0 = n_rd;
		foreach (lru[k])
			fetch(lru[k], 1'b1);
		`CHK("lru reads", 4, n_rd - r0)
		$display("test burst done");
	endtask
	task automatic t_cti();
		int i;
		int r0;
		r0 = n_rd;
		fetch(32'h4000_0900, 1'b1);
		fetch_req.cti = 1'b1;
		for (i = 0; i < 300 && ahb_out.htrans != HTRANS_IDLE; i++)
			cyc();
		fetch_req.cti = 1'b0;
		fetch(32'h4000_091C, 1'b1);
		`CHK("abandon reads", 2, n_rd - r0)
		cache_control_word[CCW_BURST_BIT] = 1'b0;
		r0 = n_rd;
		fetch(32'h4000_0D00, 1'b1);
		fetch(32'h4000_0D04, 1'b1);
		fetch(32'h4000_0D00, 1'b1);
		`CHK("single fill reads", 2, n_rd - r0)
		cache_control_word[CCW_BURST_BIT] = 1'b1;
		$display("test abandon done");
	endtask
	task automatic t_store();
		logic [1:0] sz [5] = '{SIZE_BYTE, SIZE_HALF, 2'h2, 2'h2, 2'h2};
		logic [31:0] ad [5] = '{32'h4000_0801, 32'h4000_0806, 32'h4000_0808, 32'h4000_080C,
			32'h4000_0810};
		logic [31:0] ex [5] = '{32'hABAB_ABAB, 32'h1234_1234, 32'hCAFE_0001, 32'h0BAD_F00D,
			32'h1357_9BDF};
		int r0;
		slow = 1'b1;
		for (int k = 0; k < 5; k++)
			access(1'b1, 8'h0A, sz[k], ad[k], k == 0 ? 32'hAB : k == 1 ? 32'h1234 : ex[k]);
		r0 = n_rd;
		for (int k = 0; k < 5; k++)
		begin
			access(1'b0, k < 3 ? ASI_FORCED_MISS : 8'h0A, 2'h2, ad[k] & 32'hFFFF_FFFC, 32'h0);
			`CHK("load data", ex[k], rd)
		end
		access(1'b0, 8'h0A, 2'h2, 32'h4000_080C, 32'h0);
		access(1'b0, ASI_FORCED_MISS, 2'h2, 32'h4000_080C, 32'h0);
		`CHK("load reads", 6, n_rd - r0)
		slow = 1'b0;
		$display("test store done");
	endtask
	task automatic t_errors();
		int r0;
		tq.delete();
		err_en = 1'b1;
		err_addr = 32'h4000_0A08;
		r0 = n_rd;
		fetch(32'h4000_0A08, 1'b1);
		wait_sz(tq, 1);
		`CHK("fetch fault", 1'b1, fe)
		`CHK("fetch retry", 2, n_rd - r0)
		`CHK("fetch trap", TT_IACC, tq[0][7:0])
		err_addr = 32'h4000_0B04;
		access(1'b0, 8'h0A, 2'h2, 32'h4000_0B04, 32'h0);
		wait_sz(tq, 2);
		`CHK("load fault", 1'b1, rerr)
		`CHK("load trap", TT_DACC, tq[1][7:0])
		err_addr = 32'h4000_0C00;
		access(1'b1, 8'h0A, 2'h2, 32'h4000_0C00, 32'h5555_AAAA);
		wait_sz(tq, 3);
		`CHK("write trap", TT_WERR, tq[2][7:0])
		err_en = 1'b0;
		r0 = n_rd;
		access(1'b0, 8'h0A, 2'h2, 32'h4000_0B04, 32'h0);
		`CHK("load retry", 1, n_rd - r0)
		`CHK("load data", pat(32'h4000_0B04), rd)
		$display("test errors done");
	endtask
	initial
	begin
		repeat (12) @(posedge clock);
		#1;
		srst = 1'b0;
		t_modes();
		t_burst();
		t_cti();
		t_store();
		t_errors();
		end_sim();
	end
endmodule
